/* verilog/rsc_params.svh */
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// Register word indices; byte address is four times the index
`define RSC_IDX_CHAN 10'h109
`define RSC_IDX_OPTS 10'h11A
`define RSC_IDX_STAT 10'h120

// Operating options field positions
`define RSC_OPT_CAL 0
`define RSC_OPT_RX2TX 1
`define RSC_OPT_TX2RX 2
`define RSC_OPT_SPORT 3
`define RSC_OPT_IRQ_TX 4
`define RSC_OPT_IRQ_RX 5

// Status field positions
`define RSC_ST_READY 3
`define RSC_ST_RETAIN 4
`define RSC_ST_DEEP 5

// Reset values
`define RSC_RST_CHAN 24'h00_0000
`define RSC_RST_OPTS 8'h00

// Command codes
`define RSC_CMD_OFF 8'hB0
`define RSC_CMD_IDLE 8'hB1
`define RSC_CMD_RX 8'hB2
`define RSC_CMD_TX 8'hB5
`define RSC_CMD_SLEEP 8'hBA
`define RSC_CMD_HWRST 8'hC8
`define RSC_CMD_CONFIG 8'hBB

`endif

/* verilog/rsc_pkg.sv */
package rsc_pkg;

	// Five visible radio states
	typedef enum logic [2:0] {
		radio_sleep_state,
		radio_off_state,
		radio_idle_state,
		radio_receive_state,
		radio_transmit_state
	} rsc_radio_t;

	// Internal sequencer steps, calibration phases included
	typedef enum logic [2:0] {
		seq_sleep,
		seq_off,
		seq_idle_cal,
		seq_idle,
		seq_rx_cal,
		seq_rx,
		seq_tx_cal,
		seq_tx
	} rsc_seq_t;

	// Whole state of the controller
	typedef struct packed {
		rsc_seq_t seq;
		logic deep2;
		logic retain_ok;
		logic por_pend;
		logic sclk_d;
		logic cs_d;
		logic [2:0] bit_cnt;
		logic [7:0] shreg;
		logic [23:0] chan;
		logic [7:0] opts;
		logic [23:0] synth_chan;
		logic [31:0] prdata;
		logic pslverr;
		logic irq_flag;
		logic synth_cal_start;
		logic filter_cal_start;
		logic config_apply;
		logic pram_clear;
		logic mcr_defaults;
		logic pkt_tx_start;
		logic tx_bit;
	} rsc_state_t;

endpackage : rsc_pkg

/* verilog/rsc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module rsc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} rsc_sync_t;

	rsc_sync_t cur_ff;
	rsc_sync_t nxt_sync;

	// First stage feeds only the second
	always_comb begin
		nxt_sync.s1 = d;
		nxt_sync.s2 = cur_ff.s1;
	end

	// Two flops against metastability
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_sync;
		end
	end

	assign q = cur_ff.s2;

endmodule : rsc_sync

`default_nettype wire

/* verilog/rsc_top.sv */
// Contract
// [RQ1] Exactly five radio states exist
// [RQ2] One-byte SPI commands drive state changes
// [RQ3] Sleep command only from off or idle
// [RQ4] Wake on chip select low or timer
// [RQ5] Host programs wake timer before sleep
// [RQ6] Hard reset: deep sleep, no timer, retention lost
// [RQ7] Sleep: interrupt low, other pins floating
// [RQ8] Host loads retained config before leaving off
// [RQ9] Off to idle calibrates filter if enabled
// [RQ10] Idle: regulators on, accepts transmit/receive
// [RQ11] Transmit: synth calibrated, amplifier on, channel
// [RQ12] Packet transmit starts automatically on entry
// [RQ13] After send: amplifier off, idle, interrupt
// [RQ14] Raw serial transmit sends serial pin data
// [RQ15] Host ends raw serial transmit with idle
// [RQ16] Receive: synth calibrated, receive chain on
// [RQ17] Valid packet returns to idle, interrupt
// [RQ18] Raw serial receive stays until idle command
// [RQ19] Raw serial suppresses end-of-frame transitions
// [RQ20] Auto turnaround only when enabled
// [RQ21] Power-on: off, packet RAM cleared, defaults
// [RQ22] Host wakes, polls ready, loads config
// [RQ23] Hard reset wake registers power-on reset
// [RQ24] Go-off from idle drops RF regulators
// [RQ25] Chip select wake is no power-on reset
// [RQ26] Forbidden commands are ignored
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"

module rsc_top (
	input wire logic clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// SPI link from host
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso_o,
	output logic spi_miso_oe,
	// Raw serial transmit pin and wake-up timer
	input wire logic serial_tx_data_pin,
	input wire logic wakeup_expired,
	output logic wakeup_timer_en,
	// Radio datapath handshakes, same clock
	input wire logic filter_cal_done,
	input wire logic synth_cal_done,
	input wire logic tx_packet_done,
	input wire logic rx_packet_valid,
	// Controls to the radio
	output rsc_pkg::rsc_radio_t radio_state,
	output logic cmd_ready,
	output logic rf_vco_reg_en,
	output logic synth_en,
	output logic [23:0] synth_chan,
	output logic synth_cal_start,
	output logic filter_cal_start,
	output logic pa_en,
	output logic rx_chain_en,
	output logic pkt_tx_start,
	output logic sport_tx_bit,
	output logic sport_sel,
	output logic config_apply,
	output logic pram_clear,
	output logic mcr_defaults,
	output logic retain_valid,
	// Pins that float or are held in sleep
	output logic irq_line_o,
	output logic irq_line_oe,
	output logic gp_oe
);

	import rsc_pkg::*;

	rsc_state_t cur_ff;
	rsc_state_t nxt_st;

	logic [4:0] sync_q;
	logic cs_n_s;
	logic sclk_s;
	logic mosi_s;
	logic sdata_s;
	logic wake_s;
	logic sclk_rise;
	logic cs_fall;
	logic byte_done;
	logic [7:0] cmd_byte;
	logic [9:0] reg_idx;
	logic busy;
	logic sport;

	// Link, serial data and wake pins pass two flops
	rsc_sync #(.W(5)) u_sync (.clk(clk), .nrst(nrst), .q(sync_q),
		.d({spi_cs_n, spi_sclk, spi_mosi, serial_tx_data_pin, wakeup_expired}));
	assign {cs_n_s, sclk_s, mosi_s, sdata_s, wake_s} = sync_q;

	// SPI mode 0: bits taken on sampled rising clock, MSB first
	assign sclk_rise = sclk_s & ~cur_ff.sclk_d;
	// Wake needs a falling select; the select that carried the sleep byte is still low
	assign cs_fall = cur_ff.cs_d & ~cs_n_s;
	assign byte_done = sclk_rise & ~cs_n_s & (cur_ff.bit_cnt == 3'd7); // [RQ2]
	assign cmd_byte = {cur_ff.shreg[6:0], mosi_s};
	assign reg_idx = paddr[11:2];
	assign sport = cur_ff.opts[`RSC_OPT_SPORT];

	// Calibration steps and pending init hold off new commands
	assign busy = cur_ff.por_pend | (cur_ff.seq == seq_idle_cal) | (cur_ff.seq == seq_rx_cal)
		| (cur_ff.seq == seq_tx_cal) | (cur_ff.seq == seq_sleep);

	always_comb begin
		logic cmd_ok;
		logic want_rx;
		logic want_tx;
		logic want_idle;
		cmd_ok = byte_done & ~busy;
		want_rx = 1'b0;
		want_tx = 1'b0;
		want_idle = 1'b0;
		nxt_st = cur_ff;

		// Pulses last one cycle
		{nxt_st.synth_cal_start, nxt_st.filter_cal_start, nxt_st.config_apply, nxt_st.pram_clear,
			nxt_st.mcr_defaults, nxt_st.pkt_tx_start} = 6'h00;
		nxt_st.tx_bit = sdata_s; // [RQ14]

		// Byte assembly; chip select high restarts the count
		nxt_st.sclk_d = sclk_s;
		nxt_st.cs_d = cs_n_s;
		if (cs_n_s) begin
			nxt_st.bit_cnt = 3'd0;
		end else if (sclk_rise) begin
			nxt_st.bit_cnt = cur_ff.bit_cnt + 3'd1;
			nxt_st.shreg = cmd_byte;
		end

		// Power-on actions run once after reset or deep wake
		if (cur_ff.por_pend) begin
			nxt_st.pram_clear = 1'b1; // [RQ21]
			nxt_st.mcr_defaults = 1'b1; // [RQ21]
			nxt_st.por_pend = 1'b0;
		end

		// Any new command byte acknowledges the interrupt
		if (byte_done) begin
			nxt_st.irq_flag = 1'b0;
		end

		// APB setup phase prepares read data for the access phase
		if (psel && !penable) begin
			nxt_st.pslverr = 1'b0;
			nxt_st.prdata = 32'h0000_0000;
			case (reg_idx)
				`RSC_IDX_CHAN: nxt_st.prdata = {8'h00, cur_ff.chan};
				`RSC_IDX_OPTS: nxt_st.prdata = {24'h00_0000, cur_ff.opts};
				`RSC_IDX_STAT: begin
					nxt_st.prdata[2:0] = radio_state;
					nxt_st.prdata[`RSC_ST_READY] = cmd_ready;
					nxt_st.prdata[`RSC_ST_RETAIN] = cur_ff.retain_ok;
					nxt_st.prdata[`RSC_ST_DEEP] = cur_ff.deep2;
				end
				default: nxt_st.pslverr = 1'b1;
			endcase
		end

		// Writes land at the access edge
		if (psel && penable && pwrite) begin
			if (reg_idx == `RSC_IDX_CHAN) begin
				nxt_st.chan = pwdata[23:0];
			end
			if (reg_idx == `RSC_IDX_OPTS) begin
				nxt_st.opts = pwdata[7:0];
			end
		end

		// Radio state sequencing
		case (cur_ff.seq)
			seq_sleep: begin
				if (cs_fall) begin
					nxt_st.seq = seq_off; // [RQ4]
					if (cur_ff.deep2) begin
						nxt_st.por_pend = 1'b1; // [RQ23]
						nxt_st.deep2 = 1'b0;
					end // [RQ25]
				end else if (wake_s && !cur_ff.deep2) begin
					nxt_st.seq = seq_off; // [RQ4]
				end
			end
			seq_off: begin
				if (cmd_ok) begin
					case (cmd_byte)
						`RSC_CMD_IDLE: begin
							if (cur_ff.opts[`RSC_OPT_CAL]) begin
								nxt_st.seq = seq_idle_cal; // [RQ9]
								nxt_st.filter_cal_start = 1'b1;
							end else begin
								nxt_st.seq = seq_idle;
							end
						end
						`RSC_CMD_SLEEP: nxt_st.seq = seq_sleep; // [RQ3]
						`RSC_CMD_CONFIG: begin
							nxt_st.config_apply = 1'b1;
							nxt_st.retain_ok = 1'b1;
						end
						default: ; // [RQ26]
					endcase
				end
			end
			seq_idle_cal: begin
				if (filter_cal_done) begin
					nxt_st.seq = seq_idle; // [RQ9]
				end
			end
			seq_idle: begin
				if (cmd_ok) begin
					case (cmd_byte)
						`RSC_CMD_OFF: nxt_st.seq = seq_off; // [RQ24]
						`RSC_CMD_SLEEP: nxt_st.seq = seq_sleep; // [RQ3]
						`RSC_CMD_RX: want_rx = 1'b1; // [RQ10]
						`RSC_CMD_TX: want_tx = 1'b1; // [RQ10]
						`RSC_CMD_CONFIG: begin
							nxt_st.config_apply = 1'b1;
							nxt_st.retain_ok = 1'b1;
						end
						default: ; // [RQ26]
					endcase
				end
			end
			seq_rx_cal: begin
				if (synth_cal_done) begin
					nxt_st.seq = seq_rx; // [RQ16]
				end
			end
			seq_tx_cal: begin
				if (synth_cal_done) begin
					nxt_st.seq = seq_tx; // [RQ11]
					nxt_st.pkt_tx_start = ~sport; // [RQ12]
				end
			end
			seq_rx: begin
				if (cmd_ok) begin
					case (cmd_byte)
						`RSC_CMD_IDLE: want_idle = 1'b1; // [RQ18]
						`RSC_CMD_RX: want_rx = 1'b1;
						`RSC_CMD_TX: want_tx = 1'b1;
						default: ; // [RQ26]
					endcase
				end else if (rx_packet_valid && !sport) begin // [RQ19]
					nxt_st.irq_flag = nxt_st.irq_flag | cur_ff.opts[`RSC_OPT_IRQ_RX]; // [RQ17]
					if (cur_ff.opts[`RSC_OPT_RX2TX]) begin
						want_tx = 1'b1; // [RQ20]
					end else begin
						want_idle = 1'b1; // [RQ17]
					end
				end
			end
			seq_tx: begin
				if (cmd_ok) begin
					case (cmd_byte)
						`RSC_CMD_IDLE: want_idle = 1'b1; // [RQ15]
						`RSC_CMD_RX: want_rx = 1'b1;
						`RSC_CMD_TX: want_tx = 1'b1;
						default: ; // [RQ26]
					endcase
				end else if (tx_packet_done && !sport) begin // [RQ19]
					nxt_st.irq_flag = nxt_st.irq_flag | cur_ff.opts[`RSC_OPT_IRQ_TX]; // [RQ13]
					if (cur_ff.opts[`RSC_OPT_TX2RX]) begin
						want_rx = 1'b1; // [RQ20]
					end else begin
						want_idle = 1'b1; // [RQ13]
					end
				end
			end
			default: nxt_st.seq = seq_off;
		endcase

		// Shared entry actions; channel is frozen at calibration
		if (want_idle) begin
			nxt_st.seq = seq_idle;
		end
		if (want_rx) begin
			nxt_st.seq = seq_rx_cal; // [RQ16]
			nxt_st.synth_cal_start = 1'b1;
			nxt_st.synth_chan = cur_ff.chan;
		end
		if (want_tx) begin
			nxt_st.seq = seq_tx_cal; // [RQ11]
			nxt_st.synth_cal_start = 1'b1;
			nxt_st.synth_chan = cur_ff.chan; // [RQ11]
		end

		// Hard reset overrides everything, from any awake state not calibrating or running power-on init
		if (cmd_ok && cmd_byte == `RSC_CMD_HWRST) begin
			nxt_st.seq = seq_sleep; // [RQ6]
			nxt_st.deep2 = 1'b1; // [RQ6]
			nxt_st.retain_ok = 1'b0; // [RQ6]
		end
	end

	// Single state register; reset is the power-on event
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cur_ff <= '0;
			cur_ff.seq <= seq_off; // [RQ21]
			cur_ff.por_pend <= 1'b1; // [RQ21]
			cur_ff.chan <= `RSC_RST_CHAN;
			cur_ff.opts <= `RSC_RST_OPTS;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	// Visible state folds calibration steps into their target
	always_comb begin
		case (cur_ff.seq)
			seq_sleep: radio_state = radio_sleep_state; // [RQ1]
			seq_off: radio_state = radio_off_state;
			seq_idle_cal, seq_idle: radio_state = radio_idle_state;
			seq_rx_cal, seq_rx: radio_state = radio_receive_state;
			seq_tx_cal, seq_tx: radio_state = radio_transmit_state;
			default: radio_state = radio_off_state;
		endcase
	end

	// Zero wait state APB
	assign pready = 1'b1;
	assign {prdata, pslverr} = {cur_ff.prdata, cur_ff.pslverr};

	// MISO high tells the host the device is awake and ready
	assign cmd_ready = ~busy;
	assign spi_miso_o = cmd_ready; // [RQ22]
	assign spi_miso_oe = ~cs_n_s & (cur_ff.seq != seq_sleep);

	// Power and block enables per state
	assign rf_vco_reg_en = (cur_ff.seq != seq_sleep) & (cur_ff.seq != seq_off); // [RQ10]
	assign synth_en = (radio_state == radio_receive_state) | (radio_state == radio_transmit_state);
	assign pa_en = (cur_ff.seq == seq_tx); // [RQ13]
	assign rx_chain_en = (radio_state == radio_receive_state); // [RQ16]
	assign synth_chan = cur_ff.synth_chan;
	assign {synth_cal_start, filter_cal_start, pkt_tx_start} =
		{cur_ff.synth_cal_start, cur_ff.filter_cal_start, cur_ff.pkt_tx_start};
	assign sport_sel = sport; // [RQ14]
	assign sport_tx_bit = cur_ff.tx_bit;
	assign {config_apply, pram_clear, mcr_defaults} =
		{cur_ff.config_apply, cur_ff.pram_clear, cur_ff.mcr_defaults};
	assign retain_valid = cur_ff.retain_ok;

	// Deep sleep keeps the wake timer off
	assign wakeup_timer_en = (cur_ff.seq == seq_sleep) & ~cur_ff.deep2; // [RQ6]

	// Sleep drives the interrupt low and floats the rest
	assign irq_line_o = (cur_ff.seq != seq_sleep) & cur_ff.irq_flag; // [RQ7]
	assign irq_line_oe = 1'b1;
	assign gp_oe = (cur_ff.seq != seq_sleep); // [RQ7]

endmodule : rsc_top

`default_nettype wire

/* bench/rsc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module rsc_monitor (
	input wire logic clk,
	input wire logic nrst,
	input wire rsc_pkg::rsc_radio_t radio_state,
	input wire logic irq_line_o,
	input wire logic gp_oe,
	input wire logic pa_en,
	input wire logic rx_chain_en,
	input wire logic pkt_tx_start,
	input wire logic sport_sel,
	input wire logic sport_tx_bit,
	input wire logic serial_tx_data_pin,
	input wire logic tx_packet_done,
	input wire logic synth_cal_done,
	input wire logic rf_vco_reg_en,
	input wire logic pram_clear,
	input wire logic mcr_defaults,
	input wire logic filter_cal_start,
	input wire logic cmd_ready
);
	import rsc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Pin and power relations per state
	sleep_pins_a: assert property (radio_state == radio_sleep_state |-> !irq_line_o && !gp_oe)
		else $error("pins live in sleep");
	off_regs_a: assert property (radio_state == radio_off_state |-> !rf_vco_reg_en)
		else $error("regulators on in off");
	idle_regs_a: assert property (radio_state == radio_idle_state && cmd_ready |-> rf_vco_reg_en)
		else $error("regulators off in idle");
	rx_chain_a: assert property (rx_chain_en |-> radio_state == radio_receive_state)
		else $error("receive chain outside receive");
	// Amplifier only after a finished synth calibration
	pa_entry_a: assert property ($rose(pa_en) |-> $past(synth_cal_done) && radio_state == radio_transmit_state)
		else $error("amplifier on without calibration");
	pkt_start_a: assert property (pkt_tx_start |-> !sport_sel && pa_en)
		else $error("packet start out of place");
	tx_end_a: assert property (radio_state == radio_transmit_state && tx_packet_done && !sport_sel |=> !pa_en)
		else $error("amplifier stays on after send");
	// Sync chain plus bit register give a fixed three-cycle lag
	sport_bit_a: assert property (sport_sel && pa_en |-> sport_tx_bit == $past(serial_tx_data_pin, 3))
		else $error("serial bit not passed");
	por_pulse_a: assert property (pram_clear |-> mcr_defaults && radio_state == radio_off_state)
		else $error("power-on clears outside off");
	filter_cal_a: assert property (filter_cal_start |-> radio_state == radio_idle_state && !cmd_ready)
		else $error("filter cal out of place");
endmodule : rsc_monitor

bind rsc_top rsc_monitor rsc_monitor_inst (.clk(clk), .nrst(nrst), .radio_state(radio_state),
	.irq_line_o(irq_line_o), .gp_oe(gp_oe), .pa_en(pa_en), .rx_chain_en(rx_chain_en),
	.pkt_tx_start(pkt_tx_start), .sport_sel(sport_sel), .sport_tx_bit(sport_tx_bit),
	.serial_tx_data_pin(serial_tx_data_pin), .tx_packet_done(tx_packet_done),
	.synth_cal_done(synth_cal_done), .rf_vco_reg_en(rf_vco_reg_en), .pram_clear(pram_clear),
	.mcr_defaults(mcr_defaults), .filter_cal_start(filter_cal_start), .cmd_ready(cmd_ready));

`default_nettype wire

/* bench/rsc_host.sv */
`timescale 1ns/1ps
`default_nettype none

module rsc_host (
	input wire logic clk,
	input wire logic miso,
	output var logic cs_n,
	output var logic sclk,
	output var logic mosi
);
	// Link clock idles low outside frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end

	// Select, wait for ready on data-out, then n bits MSB first
	task automatic send(input logic [7:0] b, input int n);
		int k;
		cs_n <= 1'b0;
		for (k = 0; k < 400 && miso !== 1'b1; k++) begin
			@(posedge clk);
		end
		for (k = 7; k > 7 - n; k--) begin
			mosi <= b[k];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		mosi <= ~mosi; // Released line shows no stale bit
		repeat (8) @(posedge clk);
	endtask : send
endmodule : rsc_host

`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"

module testbench;
	import rsc_pkg::*;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, sdin, wake;
	logic cs_n, sclk, mosi, mo, moe, rdy, pa, rxe, irq, gpoe, wten, rfen, sen, rv, ioe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] ev;
	logic [23:0] schan;
	rsc_radio_t st;
	int n_mismatch = 0;
	int n_tests = 0;
	localparam logic [11:0] A_CH = {`RSC_IDX_CHAN, 2'b00};
	localparam logic [11:0] A_OP = {`RSC_IDX_OPTS, 2'b00};
	localparam logic [11:0] A_ST = {`RSC_IDX_STAT, 2'b00};

	rsc_top rsc_top_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso_o(mo), .spi_miso_oe(moe),
		.serial_tx_data_pin(sdin), .wakeup_expired(wake), .wakeup_timer_en(wten),
		.filter_cal_done(ev[0]), .synth_cal_done(ev[1]), .tx_packet_done(ev[2]), .rx_packet_valid(ev[3]),
		.radio_state(st), .cmd_ready(rdy), .rf_vco_reg_en(rfen), .synth_en(sen), .synth_chan(schan),
		.synth_cal_start(), .filter_cal_start(), .pa_en(pa), .rx_chain_en(rxe), .pkt_tx_start(),
		.sport_tx_bit(), .sport_sel(), .config_apply(), .pram_clear(), .mcr_defaults(),
		.retain_valid(rv), .irq_line_o(irq), .irq_line_oe(ioe), .gp_oe(gpoe));
	// Undriven data-out reads low, so a sleeping part never looks ready
	rsc_host rsc_host_inst (.clk(clk), .miso(moe & mo), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; an edge passes after release; on a read d is the expected word
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		if (!w) chk(prdata, d);
		chk({31'h0, pslverr}, {31'h0, e});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wst(input rsc_radio_t x);
		int k;
		for (k = 0; k < 60 && st !== x; k++) @(posedge clk);
		chk({29'h0, st}, {29'h0, x});
	endtask : wst

	task automatic go(input logic [7:0] b, input rsc_radio_t x);
		rsc_host_inst.send(b, 8);
		wst(x);
	endtask : go

	task automatic fire(input logic [3:0] m);
		ev <= m;
		@(posedge clk);
		ev <= 4'h0;
		@(posedge clk);
	endtask : fire

	task automatic report_and_stop();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Long span covers the 1 ms hard-reset pause
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		{nrst, psel, penable, pwrite, sdin, wake, ev, paddr, pwdata} = '0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		apb(1'b0, A_ST, 32'h0000_0009, 1'b0);
		apb(1'b0, 12'h400, 32'h0000_0000, 1'b1);
		apb(1'b1, A_CH, 32'h0012_3456, 1'b0);
		apb(1'b0, A_CH, 32'h0012_3456, 1'b0);
		go(`RSC_CMD_TX, radio_off_state);
		go(`RSC_CMD_CONFIG, radio_off_state);
		chk({31'h0, rv}, 32'h0000_0001);
		apb(1'b1, A_OP, 32'h0000_0025, 1'b0);
		go(`RSC_CMD_IDLE, radio_idle_state);
		apb(1'b0, A_ST, 32'h0000_0012, 1'b0);
		fire(4'h1);
		apb(1'b0, A_ST, 32'h0000_001A, 1'b0);
		chk({31'h0, rfen}, 32'h0000_0001);
		go(`RSC_CMD_TX, radio_transmit_state);
		fire(4'h2);
		chk({6'h00, pa, sen, schan}, {6'h00, 2'b11, 24'h12_3456});
		fire(4'h4);
		wst(radio_receive_state);
		chk({31'h0, pa}, 32'h0000_0000);
		fire(4'h2);
		chk({31'h0, rxe}, 32'h0000_0001);
		fire(4'h8);
		wst(radio_idle_state);
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b1, A_OP, 32'h0000_0008, 1'b0);
		go(`RSC_CMD_TX, radio_transmit_state);
		fire(4'h2);
		sdin <= 1'b1;
		fire(4'h4);
		wst(radio_transmit_state);
		go(`RSC_CMD_IDLE, radio_idle_state);
		// Wake timer armed before sleep; its expiry comes later
		wake <= 1'b0;
		go(`RSC_CMD_SLEEP, radio_sleep_state);
		chk({27'h0, gpoe, irq, wten, rfen, ioe}, 32'h0000_0005);
		wake <= 1'b1;
		wst(radio_off_state);
		wake <= 1'b0;
		go(`RSC_CMD_HWRST, radio_sleep_state);
		apb(1'b0, A_ST, 32'h0000_0020, 1'b0);
		chk({31'h0, wten}, 32'h0000_0000);
		repeat (20000) @(posedge clk);
		rsc_host_inst.send(8'h00, 0);
		wst(radio_off_state);
		chk({31'h0, rdy}, 32'h0000_0001);
		apb(1'b0, A_ST, 32'h0000_0009, 1'b0);
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
